// ===== shared/flash_host_map.svh
// Constants for the parallel flash host controller.
// Contract
// RULE_01 - Bottom boot sectors decoded from bits 18:12. In byte mode the code takes bits 18:12 of the byte address in req.addr.
// RULE_02 - Above 0FFFFh, 64 KB sectors by bits 18:15. In byte mode the code takes bits 18:15 of the byte address in req.addr.
// RULE_03 - Byte mode adds bit -1; word uses 18:0.
// RULE_04 - Write needs write low, select low, output-enable high.
// RULE_05 - Address captured on later falling strobe.
// RULE_06 - Data captured on first rising strobe.
// RULE_07 - Protected sectors ignore program and erase.
// RULE_08 - Protected program shows polling about 1 us.
// RULE_09 - Protected erase shows toggling about 50 us.
// RULE_10 - Identification read XX02h gives protection on bit0.
// RULE_11 - Elevated reset voltage unprotects sectors temporarily.
// RULE_12 - Leaving elevated voltage restores protection.
// RULE_13 - Bad sequence returns device to read mode.
// RULE_14 - Suspend and resume valid only during erase.
// RULE_15 - Device powers up in read state.
// RULE_16 - Read/reset command holds array-read state.
// RULE_17 - Leave identification with read/reset F0.
// RULE_18 - Elevated voltage is a separate qualifier input.
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
`define CLK_PERIOD_NS 50
`define T_SETUP_NS 100
`define T_PULSE_NS 100
`define T_HOLD_NS 50
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC `CYC_UP(`T_SETUP_NS)
`define PULSE_CYC `CYC_UP(`T_PULSE_NS)
`define HOLD_CYC `CYC_UP(`T_HOLD_NS)
`define UNLOCK_ADDR1 20'h00555
`define UNLOCK_ADDR2 20'h002aa
`define UNLOCK_DATA1 16'h00aa
`define UNLOCK_DATA2 16'h0055
`define CMD_RESET 16'h00f0
`define CMD_ID 16'h0090
`define CMD_PROGRAM 16'h00a0
`define CMD_ERASE 16'h0080
`define CMD_SECTOR 16'h0030
`define CMD_CHIP 16'h0010
`define CMD_SUSPEND 16'h00b0
`define CMD_RESUME 16'h0030
`define PROT_OFFSET 20'h00002
`endif

// ===== shared/flash_host_pkg.sv
// Types for the parallel flash host controller.
`default_nettype none
package flash_host_pkg;
	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_RESET = 4'h1,
		OP_ID_ENTER = 4'h2,
		OP_PROT_QUERY = 4'h3,
		OP_PROGRAM = 4'h4,
		OP_SECTOR_ERASE = 4'h5,
		OP_CHIP_ERASE = 4'h6,
		OP_SUSPEND = 4'h7,
		OP_RESUME = 4'h8
	} op_t;
	typedef struct packed {
		op_t op;
		logic [19:0] addr;
		logic [15:0] data;
	} req_t;
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [19:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
	} pins_t;
endpackage : flash_host_pkg
`default_nettype wire

// ===== rtl/flash_host.sv
// Host that drives a parallel NOR flash through its strobes.
`include "flash_host_map.svh"
`default_nettype none
module flash_host (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic req_valid,
	input wire flash_host_pkg::req_t req,
	input wire logic byte_mode,
	input wire logic elevated_id_voltage_req,
	input wire logic [15:0] dq_in,
	output logic req_ready,
	output logic done,
	output logic [15:0] rd_data,
	output logic sector_protected,
	output logic [4:0] sector_select,
	output logic elevated_id_voltage,
	output flash_host_pkg::pins_t pins
);
	// ****************************************
	// State.
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SETUP = 3'h1,
		ST_PULSE = 3'h2,
		ST_HOLD = 3'h3,
		ST_NEXT = 3'h4
	} st_t;
	typedef struct packed {
		st_t st;
		logic [3:0] cnt;
		logic [2:0] step;
		logic [2:0] nsteps;
		logic rd;
		flash_host_pkg::req_t cur;
		logic done;
		logic [15:0] rd_data;
		logic prot;
		logic [4:0] sect;
		logic hv;
		flash_host_pkg::pins_t pins;
	} state_t;
	state_t s_ff;
	state_t nxt_s;
	logic [19:0] a_w;
	logic [15:0] d_w;
	logic rd_w;
	logic [2:0] n_w;

	function automatic logic [4:0] decode_sector(input logic [19:0] ba);
		logic [6:0] hi;
		hi = ba[18:12];
		if (hi[6:3] != 4'h0) begin // RULE_02
			decode_sector = 5'(hi[6:3] + 4'h3);
		end else if (hi[2]) begin // RULE_01
			decode_sector = 5'h03;
		end else if (hi[1]) begin
			decode_sector = {4'h0, hi[0]} + 5'h01;
		end else begin
			decode_sector = 5'h00;
		end
	endfunction : decode_sector

	// ****************************************
	// Step table: bus cycle per command step.
	// ****************************************
	always_comb begin
		n_w = 3'h1;
		rd_w = 1'b0;
		a_w = `UNLOCK_ADDR1;
		d_w = `UNLOCK_DATA1;
		case (s_ff.cur.op)
			flash_host_pkg::OP_READ: begin
				rd_w = 1'b1;
				a_w = s_ff.cur.addr;
			end
			flash_host_pkg::OP_RESET, flash_host_pkg::OP_SUSPEND,
			flash_host_pkg::OP_RESUME: begin // RULE_14 RULE_16 RULE_17
				a_w = s_ff.cur.addr;
				d_w = (s_ff.cur.op == flash_host_pkg::OP_RESET) ? `CMD_RESET :
					(s_ff.cur.op == flash_host_pkg::OP_SUSPEND) ?
					`CMD_SUSPEND : `CMD_RESUME;
			end
			default: begin // RULE_13
				n_w = (s_ff.cur.op == flash_host_pkg::OP_PROT_QUERY) ? 3'h4 :
					(s_ff.cur.op == flash_host_pkg::OP_PROGRAM) ? 3'h4 :
					(s_ff.cur.op == flash_host_pkg::OP_ID_ENTER) ? 3'h3 :
					3'h6;
				case (s_ff.step)
					3'h0, 3'h3: begin
						a_w = `UNLOCK_ADDR1;
						d_w = `UNLOCK_DATA1;
					end
					3'h1, 3'h4: begin
						a_w = `UNLOCK_ADDR2;
						d_w = `UNLOCK_DATA2;
					end
					default: begin
						a_w = `UNLOCK_ADDR1;
						d_w = `CMD_ERASE;
					end
				endcase
				if (s_ff.step == 3'h2) begin
					d_w = (s_ff.cur.op == flash_host_pkg::OP_PROGRAM) ?
						`CMD_PROGRAM : (s_ff.cur.op == flash_host_pkg::OP_ID_ENTER
						|| s_ff.cur.op == flash_host_pkg::OP_PROT_QUERY) ?
						`CMD_ID : `CMD_ERASE;
				end
				if (s_ff.step == 3'h3 &&
					s_ff.cur.op == flash_host_pkg::OP_PROT_QUERY) begin // RULE_10
					rd_w = 1'b1;
					a_w = {s_ff.cur.addr[19:12], 12'h000} |
						(byte_mode ? `PROT_OFFSET << 1 : `PROT_OFFSET);
				end
				if (s_ff.step == 3'h3 &&
					s_ff.cur.op == flash_host_pkg::OP_PROGRAM) begin
					a_w = s_ff.cur.addr;
					d_w = s_ff.cur.data;
				end
				if (s_ff.step == 3'h5) begin
					a_w = (s_ff.cur.op == flash_host_pkg::OP_SECTOR_ERASE) ?
						s_ff.cur.addr : `UNLOCK_ADDR1;
					d_w = (s_ff.cur.op == flash_host_pkg::OP_SECTOR_ERASE) ?
						`CMD_SECTOR : `CMD_CHIP;
				end
				if (byte_mode && !rd_w && !(s_ff.step == 3'h3 &&
					s_ff.cur.op == flash_host_pkg::OP_PROGRAM) &&
					!(s_ff.step == 3'h5 && s_ff.cur.op ==
					flash_host_pkg::OP_SECTOR_ERASE)) begin // RULE_03
					a_w = {a_w[18:0], 1'b0};
				end
			end
		endcase
	end

	// ****************************************
	// Sequencer.
	// ****************************************
	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.hv = elevated_id_voltage_req; // RULE_11 RULE_12 RULE_18
		case (s_ff.st)
			ST_IDLE: begin // RULE_15
				if (req_valid) begin
					nxt_s.cur = req;
					nxt_s.step = 3'h0;
					nxt_s.sect = decode_sector(req.addr);
					nxt_s.st = ST_NEXT;
				end
			end
			ST_NEXT: begin
				nxt_s.nsteps = n_w;
				nxt_s.rd = rd_w;
				nxt_s.pins.addr = a_w;
				nxt_s.pins.dq_out = d_w;
				nxt_s.pins.dq_oe = !rd_w;
				nxt_s.cnt = 4'(`SETUP_CYC);
				nxt_s.st = ST_SETUP;
			end
			ST_SETUP: begin
				nxt_s.pins.ce_n = 1'b0; // RULE_05
				nxt_s.pins.oe_n = !s_ff.rd;
				nxt_s.pins.we_n = s_ff.rd; // RULE_04
				nxt_s.cnt = 4'(`PULSE_CYC);
				nxt_s.st = ST_PULSE;
			end
			ST_PULSE: begin
				if (s_ff.cnt > 4'h1) begin
					nxt_s.cnt = s_ff.cnt - 4'h1;
				end else begin
					if (s_ff.rd) begin
						nxt_s.rd_data = dq_in;
						nxt_s.prot = dq_in[0];
					end
					nxt_s.pins.we_n = 1'b1; // RULE_06
					nxt_s.pins.oe_n = 1'b1;
					nxt_s.cnt = 4'(`HOLD_CYC);
					nxt_s.st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				nxt_s.pins.ce_n = 1'b1;
				if (s_ff.cnt > 4'h1) begin
					nxt_s.cnt = s_ff.cnt - 4'h1;
				end else if (s_ff.step + 3'h1 >= s_ff.nsteps) begin
					nxt_s.pins.dq_oe = 1'b0;
					nxt_s.done = 1'b1;
					nxt_s.st = ST_IDLE;
				end else begin
					nxt_s.step = s_ff.step + 3'h1;
					nxt_s.st = ST_NEXT;
				end
			end
			default: nxt_s.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '0;
			s_ff.pins.ce_n <= 1'b1;
			s_ff.pins.we_n <= 1'b1;
			s_ff.pins.oe_n <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (nxt_s.st == ST_IDLE);
		end
	end

	assign done = s_ff.done;
	assign rd_data = s_ff.rd_data;
	assign sector_protected = s_ff.prot;
	assign sector_select = s_ff.sect;
	assign elevated_id_voltage = s_ff.hv;
	assign pins = s_ff.pins;

	// ****************************************
	// Checks.
	// ****************************************
	sequence write_low;
		!pins.we_n;
	endsequence
	chk_write_qualify: assert property (@(posedge sys_clk) disable iff (!arst_n)
		write_low |-> !pins.ce_n && pins.oe_n) // RULE_04
		else $error("write strobe without select or with output enable");
	chk_addr_stable: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!pins.we_n && !$past(pins.we_n) |-> $stable(pins.addr)) // RULE_05
		else $error("address moved during write pulse");
	chk_data_stable: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(pins.we_n) |-> $stable(pins.dq_out) && !pins.ce_n) // RULE_06
		else $error("data or select changed at write release");
	chk_no_contend: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!pins.oe_n |-> !pins.dq_oe) // RULE_04
		else $error("bus driven during read");
	chk_done_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
		done |=> !done) // RULE_13
		else $error("done longer than one cycle");
	chk_sector_hi: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_ff.st == ST_NEXT && s_ff.step == 3'h0 && s_ff.cur.addr[18:15] != 4'h0
		|-> sector_select == 5'(s_ff.cur.addr[18:15] + 4'h3)) // RULE_02
		else $error("uniform sector decode wrong");
	chk_sector_lo: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_ff.st == ST_NEXT && s_ff.cur.addr[18:14] == 5'h01
		|-> sector_select == 5'h03) // RULE_01
		else $error("boot sector decode wrong");
	chk_hv_follow: assert property (@(posedge sys_clk) disable iff (!arst_n)
		elevated_id_voltage_req |=> elevated_id_voltage) // RULE_11
		else $error("elevated voltage request not applied");
endmodule : flash_host
`default_nettype wire

// ===== dv/flash_dev_model.sv
// Behavioural bottom-boot flash device facing the host bench.
`default_nettype none
module flash_dev_model #(parameter logic [18:0] PROT = 19'h00021) (
	input wire flash_host_pkg::pins_t p,
	input wire logic byte_mode,
	input wire logic elevated,
	output logic [15:0] dq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [logic [19:0]];
	logic [18:0] era = '0;
	logic [19:0] wa, ra;
	realtime bend = 0;
	bit wr, idm, pst, pb, tog, drv;
	int step = 0;
	initial dq = 16'h0;
	function automatic int sec(logic [19:0] w);
		return w[18:15] ? 3 + w[18:15] : w[14] ? 3 : w[13] ? 1 + w[12] : 0;
	endfunction : sec
	function automatic logic [19:0] wadr(logic [19:0] a);
		return byte_mode ? {1'b0, a[19:1]} : a;
	endfunction : wadr
	task automatic cmd(logic [19:0] w, logic [15:0] d);
		int n;
		bit lk;
		n = 0;
		lk = PROT[sec(w)] && !elevated;
		if (step == 8 && lk) begin
			bend = $realtime + 1000.0;
			pst = 1;
			pb = d[7];
		end else if (step == 8)
			mem[w] = d;
		else if (step == 5 && d[7:0] == 8'h30 && lk) begin
			bend = $realtime + 50000.0;
			pst = 0;
		end else if (step == 5 && d[7:0] == 8'h30) begin
			era[sec(w)] = 1'b1;
			foreach (mem[k])
				if (sec(k) == sec(w))
					mem[k] = 16'hffff;
		end else if (step % 3 == 0 && w == 20'h555 && d[7:0] == 8'haa)
			n = step + 1;
		else if (step % 3 == 1 && w == 20'h2aa && d[7:0] == 8'h55)
			n = step + 1;
		else if (step == 2 && w == 20'h555 && d[7:0] == 8'h90)
			idm = 1;
		else if (step == 2 && w == 20'h555 && d[7:0] == 8'ha0)
			n = 8;
		else if (step == 2 && w == 20'h555 && d[7:0] == 8'h80)
			n = 3;
		else
			idm = 0;
		step = n;
	endtask : cmd
	always @(negedge p.ce_n or negedge p.we_n) begin
		if (!p.ce_n && !p.we_n && p.oe_n) begin
			wr = 1;
			wa = wadr(p.addr);
		end
	end
	always @(posedge p.ce_n or posedge p.we_n) begin
		if (wr) begin
			wr = 0;
			cmd(wa, p.dq_out);
		end
	end
	always @(negedge p.oe_n or negedge p.ce_n) begin
		if (!p.oe_n && !p.ce_n) begin
			ra = wadr(p.addr);
			tog = ~tog;
			drv = 1;
			if ($realtime < bend)
				dq = pst ? {8'h00, ~pb, 7'h00} : {9'h000, tog, 6'h00};
			else if (idm && ra[7:0] == 8'h02)
				dq = {15'h0000, PROT[sec(ra)]};
			else if (mem.exists(ra))
				dq = mem[ra];
			else
				dq = era[sec(ra)] ? 16'hffff : ra[15:0] ^ 16'h5a5a;
		end
	end
	always @(posedge p.oe_n or posedge p.ce_n) begin
		if (drv) begin
			drv = 0;
			dq = ~dq;
		end
	end
endmodule : flash_dev_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the parallel flash host.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, arst_n = 0, req_valid = 0, byte_mode = 0, elev = 0;
	flash_host_pkg::req_t req = '0;
	flash_host_pkg::pins_t pins;
	logic req_ready, done, sector_protected, elevated_id_voltage;
	logic [15:0] rd_data, dev_dq, dq_in, v;
	logic [4:0] sector_select;
	int error_cnt = 0, num_checks = 0;
	int steps [9] = '{1, 1, 3, 4, 4, 6, 6, 1, 1};
	assign dq_in = pins.dq_oe ? pins.dq_out : dev_dq;
	flash_host DUT (.sys_clk, .arst_n, .req_valid, .req, .byte_mode,
		.elevated_id_voltage_req(elev), .dq_in, .req_ready, .done, .rd_data,
		.sector_protected, .sector_select, .elevated_id_voltage, .pins);
	flash_dev_model mdl (.p(pins), .byte_mode,
		.elevated(elevated_id_voltage), .dq(dev_dq));
	initial forever #25 sys_clk = ~sys_clk;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask : tick
	task automatic op(logic [3:0] o, logic [19:0] a, logic [15:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1)
			tick();
		req = '{flash_host_pkg::op_t'(o), a, d};
		req_valid = 1'b1;
		tick();
		req_valid = 1'b0;
		do begin
			tick();
			n++;
		end while (done !== 1'b1 && n < 100);
		chk(n, 5 * steps[o]);
	endtask : op
	task automatic rd(logic [19:0] a, logic [15:0] e);
		op(4'h0, a, 16'h0);
		chk(rd_data, e);
	endtask : rd
	task automatic t_read;
		logic [19:0] ad [8] = '{20'h00000, 20'h01fff, 20'h02000, 20'h03000,
			20'h04000, 20'h08000, 20'h38000, 20'h7ffff};
		int sx [8] = '{0, 0, 1, 2, 3, 4, 10, 18};
		rd(20'h00100, 16'h5b5a);
		foreach (ad[i]) begin
			op(4'h0, ad[i], 16'h0);
			chk(sector_select, sx[i]);
		end
		$display("t_read end");
	endtask : t_read
	task automatic t_prog;
		op(4'h4, 20'h08004, 16'h1357);
		rd(20'h08004, 16'h1357);
		op(4'h4, 20'h00010, 16'h0043);
		rd(20'h00010, 16'h0080);
		#1000;
		rd(20'h00010, 16'h5a4a);
		byte_mode = 1'b1;
		op(4'h4, 20'h40008, 16'h0066);
		rd(20'h40008, 16'h0066);
		byte_mode = 1'b0;
		$display("t_prog end");
	endtask : t_prog
	task automatic t_erase;
		op(4'h5, 20'h08000, 16'h0);
		rd(20'h08004, 16'hffff);
		op(4'h5, 20'h10000, 16'h0);
		op(4'h0, 20'h10000, 16'h0);
		v = rd_data;
		chk(v & 16'hffbf, 16'h0000);
		rd(20'h10000, v ^ 16'h0040);
		#50000;
		rd(20'h10000, 16'h5a5a);
		$display("t_erase end");
	endtask : t_erase
	task automatic t_unprot;
		elev = 1'b1;
		op(4'h4, 20'h00010, 16'h0043);
		rd(20'h00010, 16'h0043);
		chk(elevated_id_voltage, 1'b1);
		elev = 1'b0;
		op(4'h4, 20'h00010, 16'h0011);
		#1000;
		rd(20'h00010, 16'h0043);
		op(4'h3, 20'h00000, 16'h0);
		chk(sector_protected, 1'b1);
		op(4'h3, 20'h08000, 16'h0);
		chk(sector_protected, 1'b0);
		op(4'h1, 20'h0, 16'h0);
		rd(20'h00002, 16'h5a58);
		$display("t_unprot end");
	endtask : t_unprot
	task automatic t_abort;
		for (int c = 7; c < 9; c++) begin
			op(4'h2, 20'h0, 16'h0);
			op(c[3:0], 20'h0, 16'h0);
			rd(20'h00002, 16'h5a58);
		end
		$display("t_abort end");
	endtask : t_abort
	initial begin
		repeat (3) @(posedge sys_clk);
		#1;
		arst_n = 1'b1;
		t_read();
		t_prog();
		t_erase();
		t_unprot();
		t_abort();
		end_sim();
	end
	initial begin
		#1000000;
		error_cnt++;
		end_sim();
	end
endmodule : testbench
`default_nettype wire
